/* rtl/ptc_pkg.sv */
// constants, register map and field layout of the period timer counter
package ptc_pkg;
	localparam int unsigned PTC_ADDR_W = 3;
	localparam int unsigned PTC_DATA_W = 8;
	localparam int unsigned PTC_COUNT_W = 16;
	localparam int unsigned PTC_PRE_W = 3;

	localparam logic [PTC_ADDR_W-1:0] PTC_OFS_CONTROL = 3'h0;
	localparam logic [PTC_ADDR_W-1:0] PTC_OFS_COUNT_LOW = 3'h1;
	localparam logic [PTC_ADDR_W-1:0] PTC_OFS_COUNT_HIGH = 3'h2;
	localparam logic [PTC_ADDR_W-1:0] PTC_OFS_PERIOD_LOW = 3'h3;
	localparam logic [PTC_ADDR_W-1:0] PTC_OFS_PERIOD_HIGH = 3'h4;
	localparam logic [PTC_ADDR_W-1:0] PTC_OFS_STATUS = 3'h5;

	localparam int unsigned PTC_BIT_TIMER_RUN = 0;
	localparam int unsigned PTC_BIT_EXT_SRC = 1;
	localparam int unsigned PTC_BIT_SYNC_BYPASS = 2;
	localparam int unsigned PTC_BIT_PRESCALE_LO = 3;
	localparam int unsigned PTC_BIT_PRESCALE_HI = 4;
	localparam int unsigned PTC_BIT_ONE_SHOT = 5;
	localparam int unsigned PTC_BIT_TRIG_RST_DIS = 6;
	localparam int unsigned PTC_BIT_SLEEP_RUN = 7;
	localparam int unsigned PTC_BIT_MATCH_FLAG = 0;

	localparam logic [PTC_DATA_W-1:0] PTC_RST_CONTROL = 8'h00;
	localparam logic [PTC_DATA_W-1:0] PTC_RST_BYTE = 8'h00;
	localparam logic [PTC_COUNT_W-1:0] PTC_RST_COUNT = 16'h0000;
	localparam logic [PTC_COUNT_W-1:0] PTC_RST_PERIOD = 16'hffff;
	localparam logic [PTC_COUNT_W-1:0] PTC_COUNT_MAX = 16'hffff;

	localparam logic [3:0] PTC_CAP_TRIG_MODE_A = 4'he;
	localparam logic [3:0] PTC_CAP_TRIG_MODE_B = 4'hf;

	localparam logic [1:0] PTC_PHASE_Q1 = 2'h0;
	localparam logic [1:0] PTC_PHASE_Q2 = 2'h1;
	localparam logic [1:0] PTC_PHASE_Q4 = 2'h3;

	// divide ratio minus one, indexed by prescale_select
	localparam logic [PTC_PRE_W-1:0] PTC_PRE_LAST_1 = 3'h0;
	localparam logic [PTC_PRE_W-1:0] PTC_PRE_LAST_2 = 3'h1;
	localparam logic [PTC_PRE_W-1:0] PTC_PRE_LAST_4 = 3'h3;
	localparam logic [PTC_PRE_W-1:0] PTC_PRE_LAST_8 = 3'h7;
endpackage : ptc_pkg

/* rtl/ptc_edge_if.sv */
// carrier between the phase generator and the external input sampler
`timescale 1ns/1ps
`default_nettype none
interface ptc_edge_if;
	logic [1:0] phase;
	logic sync_edge;
	logic async_edge;
	modport core (output phase, input sync_edge, input async_edge);
	modport sampler (input phase, output sync_edge, output async_edge);
endinterface : ptc_edge_if
`default_nettype wire

/* rtl/ptc_input_sampler.sv */
// external count input synchroniser and rising transition detector
`timescale 1ns/1ps
`default_nettype none
module ptc_input_sampler (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic external_count_input_i,
	ptc_edge_if.sampler edge_if
);
	import ptc_pkg::*;

	logic sync_a;
	logic sync_b;
	logic sync_c;
	logic [2:0] samples;
	logic next_sync_edge;
	logic next_async_edge;
	logic [2:0] next_samples;

	always_comb begin
		next_samples = samples;
		next_sync_edge = 1'b0;
		// sample on the second and fourth phases
		if (edge_if.phase == PTC_PHASE_Q2 || edge_if.phase == PTC_PHASE_Q4) begin
			next_samples = {samples[1:0], sync_b};
			// low then two highs over three adjacent samples
			next_sync_edge = ~samples[1] & samples[0] & sync_b;
		end
		// plain edge with no phase alignment
		next_async_edge = sync_b & ~sync_c;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
			samples <= 3'h0;
			edge_if.sync_edge <= 1'b0;
			edge_if.async_edge <= 1'b0;
		end else begin
			sync_a <= external_count_input_i;
			sync_b <= sync_a;
			sync_c <= sync_b;
			samples <= next_samples;
			edge_if.sync_edge <= next_sync_edge;
			edge_if.async_edge <= next_async_edge;
		end
	end
endmodule : ptc_input_sampler
`default_nettype wire

/* rtl/ptc_timer.sv */
// 16-bit period timer counter with buffered high byte and trigger reset
`timescale 1ns/1ps
`default_nettype none
module ptc_timer #(
	parameter int unsigned COUNT_W = ptc_pkg::PTC_COUNT_W
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [ptc_pkg::PTC_ADDR_W-1:0] reg_addr_i,
	input wire logic [ptc_pkg::PTC_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [ptc_pkg::PTC_DATA_W-1:0] reg_rdata_o,
	input wire logic external_count_input_i,
	input wire logic capture_one_input_i,
	input wire logic [3:0] capture_one_mode_i,
	input wire logic sleep_i,
	output logic period_match_flag_o,
	output logic timer_run_o
);
	import ptc_pkg::*;

	// elaboration-time refusal of widths the byte-wide access cannot serve
	if (COUNT_W != PTC_COUNT_W) begin : g_bad_width
		$error("ptc_timer supports a 16-bit counter only");
	end

	ptc_edge_if edge_bus ();

	ptc_input_sampler u_sampler (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.external_count_input_i(external_count_input_i),
		.edge_if(edge_bus)
	);

	logic [PTC_DATA_W-1:0] control;
	logic [PTC_DATA_W-1:0] high_buffer;
	logic [PTC_COUNT_W-1:0] count;
	logic [PTC_COUNT_W-1:0] period;
	logic [PTC_PRE_W-1:0] prescale;
	logic [1:0] phase;
	logic ext_pending;
	logic match_flag;
	logic cap_sync_a;
	logic cap_sync_b;
	logic cap_sync_c;

	logic [PTC_DATA_W-1:0] next_control;
	logic [PTC_DATA_W-1:0] next_high_buffer;
	logic [PTC_COUNT_W-1:0] next_count;
	logic [PTC_COUNT_W-1:0] next_period;
	logic [PTC_PRE_W-1:0] next_prescale;
	logic [1:0] next_phase;
	logic next_ext_pending;
	logic next_match_flag;
	logic [PTC_DATA_W-1:0] next_rdata;

	logic run;
	logic ext_src;
	logic bypass;
	logic one_shot;
	logic [PTC_PRE_W-1:0] pre_last;
	logic wr_ctrl;
	logic wr_low;
	logic wr_high;
	logic wr_per_lo;
	logic wr_per_hi;
	logic wr_status;
	logic rd_low;
	logic cap_edge;
	logic trig_ok;
	logic sleep_ok;
	logic src_event;
	logic tick;
	logic at_q1;
	logic hit;

	assign edge_bus.phase = phase;

	always_comb begin
		run = control[PTC_BIT_TIMER_RUN];
		ext_src = control[PTC_BIT_EXT_SRC];
		bypass = control[PTC_BIT_SYNC_BYPASS];
		one_shot = control[PTC_BIT_ONE_SHOT];
		at_q1 = (phase == PTC_PHASE_Q1);
		wr_ctrl = reg_write_i && reg_addr_i == PTC_OFS_CONTROL;
		wr_low = reg_write_i && reg_addr_i == PTC_OFS_COUNT_LOW;
		wr_high = reg_write_i && reg_addr_i == PTC_OFS_COUNT_HIGH;
		wr_per_lo = reg_write_i && reg_addr_i == PTC_OFS_PERIOD_LOW;
		wr_per_hi = reg_write_i && reg_addr_i == PTC_OFS_PERIOD_HIGH;
		wr_status = reg_write_i && reg_addr_i == PTC_OFS_STATUS;
		rd_low = reg_read_i && reg_addr_i == PTC_OFS_COUNT_LOW;
		cap_edge = cap_sync_b & ~cap_sync_c;
		// trigger reset only from a trigger capture mode and not disabled
		trig_ok = cap_edge && !control[PTC_BIT_TRIG_RST_DIS]
			&& (capture_one_mode_i == PTC_CAP_TRIG_MODE_A
			|| capture_one_mode_i == PTC_CAP_TRIG_MODE_B);
		// in sleep only external, bypassed, sleep-enabled counting goes on
		sleep_ok = !sleep_i || (control[PTC_BIT_SLEEP_RUN] && ext_src && bypass);
		case (control[PTC_BIT_PRESCALE_HI:PTC_BIT_PRESCALE_LO])
			2'h0: pre_last = PTC_PRE_LAST_1;
			2'h1: pre_last = PTC_PRE_LAST_2;
			2'h2: pre_last = PTC_PRE_LAST_4;
			2'h3: pre_last = PTC_PRE_LAST_8;
			default: pre_last = PTC_PRE_LAST_1;
		endcase
	end

	always_comb begin
		next_phase = phase + 2'h1;
		next_ext_pending = ext_pending;
		src_event = 1'b0;
		if (!ext_src) begin
			// internal instruction clock advances on the first phase
			src_event = at_q1;
			next_ext_pending = 1'b0;
		end else if (bypass) begin
			// external edges counted as they come
			src_event = edge_bus.async_edge;
			next_ext_pending = 1'b0;
		end else begin
			// synchronised edge held until the next first phase
			if (at_q1) begin
				src_event = ext_pending;
				next_ext_pending = edge_bus.sync_edge;
			end else if (edge_bus.sync_edge) begin
				next_ext_pending = 1'b1;
			end
		end
	end

	always_comb begin
		next_control = control;
		next_high_buffer = high_buffer;
		next_count = count;
		next_period = period;
		next_prescale = prescale;
		next_match_flag = match_flag;
		next_rdata = 8'h00;
		tick = 1'b0;
		hit = 1'b0;

		if (wr_ctrl) begin
			next_control = reg_wdata_i;
		end
		// single-shot idle timer started by the trigger edge
		if (one_shot && !run && trig_ok) begin
			next_control[PTC_BIT_TIMER_RUN] = 1'b1;
		end

		// count only while running
		if (run && sleep_ok && src_event) begin
			if (prescale == pre_last) begin
				tick = 1'b1;
				next_prescale = 3'h0;
			end else begin
				next_prescale = prescale + 3'h1;
			end
		end

		if (tick) begin
			hit = (count == period) || (count == PTC_COUNT_MAX);
			if (hit) begin
				// roll over to zero on the match edge
				next_count = PTC_RST_COUNT;
				if (one_shot) begin
					// single-shot halts itself
					next_control[PTC_BIT_TIMER_RUN] = 1'b0;
				end
			end else begin
				next_count = count + 16'h0001;
			end
		end

		// trigger reset clears the counter in either mode
		if (trig_ok) begin
			next_count = PTC_RST_COUNT;
		end

		// buffer write leaves counter and prescaler alone
		if (wr_high) begin
			next_high_buffer = reg_wdata_i;
		end
		if (wr_low) begin
			// all 16 bits load at once and beat a trigger reset
			next_count = {high_buffer, reg_wdata_i};
			next_prescale = 3'h0;
		end
		// disabling keeps the count but clears the prescaler
		if (!next_control[PTC_BIT_TIMER_RUN]) begin
			next_prescale = 3'h0;
		end

		// period accepted at any time
		if (wr_per_lo) begin
			next_period[7:0] = reg_wdata_i;
		end
		if (wr_per_hi) begin
			next_period[15:8] = reg_wdata_i;
		end

		// sticky flag, a new match beats a software clear
		if (wr_status && reg_wdata_i[PTC_BIT_MATCH_FLAG]) begin
			next_match_flag = 1'b0;
		end
		if (hit) begin
			next_match_flag = 1'b1;
		end

		if (reg_read_i) begin
			case (reg_addr_i)
				PTC_OFS_CONTROL: next_rdata = control;
				PTC_OFS_COUNT_LOW: next_rdata = count[7:0];
				PTC_OFS_COUNT_HIGH: next_rdata = high_buffer;
				PTC_OFS_PERIOD_LOW: next_rdata = period[7:0];
				PTC_OFS_PERIOD_HIGH: next_rdata = period[15:8];
				PTC_OFS_STATUS: next_rdata = {7'h00, match_flag};
				default: next_rdata = 8'h00;
			endcase
		end
		// low read captures the live high byte
		if (rd_low) begin
			next_high_buffer = count[15:8];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			control <= PTC_RST_CONTROL;
			high_buffer <= PTC_RST_BYTE;
			count <= PTC_RST_COUNT;
			period <= PTC_RST_PERIOD;
			prescale <= 3'h0;
			phase <= PTC_PHASE_Q1;
			ext_pending <= 1'b0;
			match_flag <= 1'b0;
			cap_sync_a <= 1'b0;
			cap_sync_b <= 1'b0;
			cap_sync_c <= 1'b0;
			reg_rdata_o <= 8'h00;
			period_match_flag_o <= 1'b0;
			timer_run_o <= 1'b0;
		end else begin
			control <= next_control;
			high_buffer <= next_high_buffer;
			count <= next_count;
			period <= next_period;
			prescale <= next_prescale;
			phase <= next_phase;
			ext_pending <= next_ext_pending;
			match_flag <= next_match_flag;
			cap_sync_a <= capture_one_input_i;
			cap_sync_b <= cap_sync_a;
			cap_sync_c <= cap_sync_b;
			reg_rdata_o <= next_rdata;
			period_match_flag_o <= next_match_flag;
			timer_run_o <= next_control[PTC_BIT_TIMER_RUN];
		end
	end
endmodule : ptc_timer
`default_nettype wire

/* tb/ptc_partner.sv */
// count and capture pin model
`timescale 1ns/1ps
`default_nettype none
module ptc_partner (
	input wire logic clk_i,
	output logic ext_o,
	output logic cap_o
);
	initial begin
		ext_o = 1'b0;
		cap_o = 1'b0;
	end
	task automatic pulses(input int n, input int w);
		repeat (n) begin
			@(posedge clk_i);
			ext_o <= 1'b1;
			repeat (w) @(posedge clk_i);
			ext_o <= 1'b0;
			repeat (w) @(posedge clk_i);
		end
	endtask : pulses
	task automatic capture();
		@(posedge clk_i);
		cap_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		cap_o <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask : capture
endmodule : ptc_partner
`default_nettype wire

/* tb/ptc_timer_chk.sv */
// port checker for the period timer counter
`timescale 1ns/1ps
`default_nettype none
module ptc_timer_chk (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic [ptc_pkg::PTC_ADDR_W-1:0] reg_addr_i,
	input wire logic [ptc_pkg::PTC_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [ptc_pkg::PTC_DATA_W-1:0] reg_rdata_o,
	input wire logic [3:0] capture_one_mode_i,
	input wire logic period_match_flag_o,
	input wire logic timer_run_o
);
	import ptc_pkg::*;
	logic cw;
	logic sc;
	assign cw = reg_write_i && reg_addr_i == PTC_OFS_CONTROL;
	assign sc = reg_write_i && reg_addr_i == PTC_OFS_STATUS && reg_wdata_i[0];
	default clocking dc @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);
	rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside read cycle");
	status_read_a: assert property ($past(reg_read_i && reg_addr_i == PTC_OFS_STATUS)
		|-> reg_rdata_o[0] == $past(period_match_flag_o)) else $error("status bit wrong");
	unmapped_read_a: assert property ($past(reg_read_i && reg_addr_i > PTC_OFS_STATUS)
		|-> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	flag_hold_a: assert property ($fell(period_match_flag_o) |-> $past(sc))
		else $error("flag dropped by itself");
	flag_clear_a: assert property (sc && !timer_run_o |=> !period_match_flag_o)
		else $error("flag not cleared");
	flag_cause_a: assert property ($rose(period_match_flag_o) |-> $past(timer_run_o))
		else $error("flag set while stopped");
	run_set_a: assert property ($rose(timer_run_o) |-> $past(cw && reg_wdata_i[0])
		|| $past(cw && reg_wdata_i[0], 2) || capture_one_mode_i[3:1] == 3'h7)
		else $error("run set without cause");
	run_clear_a: assert property ($fell(timer_run_o) |-> $past(cw && !reg_wdata_i[0])
		|| $past(cw && !reg_wdata_i[0], 2) || period_match_flag_o)
		else $error("run cleared without cause");
	reset_out_a: assert property ($past(reset_i) |-> !timer_run_o
		&& !period_match_flag_o && reg_rdata_o == 8'h00) else $error("bad reset outputs");
	cover property ($rose(timer_run_o) && capture_one_mode_i[3:1] == 3'h7);
	cover property ($fell(timer_run_o) && period_match_flag_o);
	cover property (sc && period_match_flag_o);
endmodule : ptc_timer_chk
bind ptc_timer ptc_timer_chk chk_u (.ref_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
	.reg_write_i, .reg_read_i, .reg_rdata_o, .capture_one_mode_i, .period_match_flag_o,
	.timer_run_o);
`default_nettype wire

/* tb/ptc_timer_tb_top.sv */
// self-checking bench for the period timer counter
`timescale 1ns/1ps
`default_nettype none
module ptc_timer_tb_top;
	import ptc_pkg::*;
	localparam logic [8:0] EXT [5] = '{9'h003, 9'h007, 9'h183, 9'h187, 9'h107};
	logic ref_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [PTC_ADDR_W-1:0] reg_addr_i = '0;
	logic [PTC_DATA_W-1:0] reg_wdata_i = '0;
	logic reg_write_i = 1'b0;
	logic reg_read_i = 1'b0;
	logic [PTC_DATA_W-1:0] reg_rdata_o;
	logic external_count_input_i;
	logic capture_one_input_i;
	logic [3:0] capture_one_mode_i = 4'h0;
	logic sleep_i = 1'b0;
	logic period_match_flag_o;
	logic timer_run_o;
	int n_mismatch = 0;
	int num_checks = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	ptc_partner prt_u (.clk_i(ref_clk_i), .ext_o(external_count_input_i),
		.cap_o(capture_one_input_i));
	ptc_timer dut_u (.ref_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
		.reg_rdata_o, .external_count_input_i, .capture_one_input_i, .capture_one_mode_i,
		.sleep_i, .period_match_flag_o, .timer_run_o);
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_write_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_read_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask : rd
	task automatic rchk(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk("register", {8'h00, e}, {8'h00, d});
	endtask : rchk
	task automatic wc(input logic [15:0] v);
		wr(PTC_OFS_COUNT_HIGH, v[15:8]);
		wr(PTC_OFS_COUNT_LOW, v[7:0]);
	endtask : wc
	task automatic rc(input logic [15:0] e);
		logic [7:0] lo;
		logic [7:0] hi;
		rd(PTC_OFS_COUNT_LOW, lo);
		rd(PTC_OFS_COUNT_HIGH, hi);
		chk("count", e, {hi, lo});
	endtask : rc
	task automatic win(input logic [7:0] c, input int w);
		wr(PTC_OFS_CONTROL, c);
		repeat (w - 2) @(posedge ref_clk_i);
		wr(PTC_OFS_CONTROL, c & 8'hfe);
	endtask : win
	task automatic flag(input logic e);
		repeat (2) @(posedge ref_clk_i);
		chk("flag", {15'h0, e}, {15'h0, period_match_flag_o});
	endtask : flag
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (10000) @(posedge ref_clk_i);
		n_mismatch++;
		close_out();
	end
	initial begin
		repeat (5) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		rchk(PTC_OFS_CONTROL, PTC_RST_CONTROL);
		rchk(3'h6, 8'h00);
		wr(PTC_OFS_COUNT_HIGH, 8'h56);
		rc(16'h0000);
		wc(16'h1234);
		repeat (20) @(posedge ref_clk_i);
		rc(16'h1234);
		for (int p = 0; p < 4; p++) begin
			win({3'h0, p[1:0], 3'h1}, 40 << p);
			rc(16'h1234 + 16'(10 * (p + 1)));
		end
		wr(PTC_OFS_CONTROL, 8'h19);
		repeat (50) @(posedge ref_clk_i);
		wc(16'h0100);
		repeat (100) @(posedge ref_clk_i);
		wr(PTC_OFS_COUNT_HIGH, 8'h77);
		repeat (212) @(posedge ref_clk_i);
		wr(PTC_OFS_CONTROL, 8'h18);
		rc(16'h0109);
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk_i);
			sleep_i <= EXT[i][8];
			wc(16'h0000);
			wr(PTC_OFS_CONTROL, EXT[i][7:0]);
			prt_u.pulses(5, 6 + 2 * i);
			repeat (12) @(posedge ref_clk_i);
			wr(PTC_OFS_CONTROL, 8'h00);
			rc((i == 2 || i == 4) ? 16'h0 : 16'h5);
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk_i);
			sleep_i <= 1'b0;
			capture_one_mode_i <= (i == 3) ? 4'h0 : {3'h7, i[0]};
			wr(PTC_OFS_CONTROL, (i == 2) ? 8'h40 : 8'h00);
			wc(16'h1234);
			prt_u.capture();
			rc((i < 2) ? 16'h0000 : 16'h1234);
		end
		@(posedge ref_clk_i);
		capture_one_mode_i <= 4'hf;
		wr(PTC_OFS_COUNT_HIGH, 8'h56);
		fork
			prt_u.capture();
			begin
				repeat (2) @(posedge ref_clk_i);
				wr(PTC_OFS_COUNT_LOW, 8'h78);
			end
		join
		rc(16'h5678);
		wr(PTC_OFS_PERIOD_LOW, 8'h03);
		wr(PTC_OFS_PERIOD_HIGH, 8'h00);
		rchk(PTC_OFS_PERIOD_LOW, 8'h03);
		wc(16'h0000);
		win(8'h01, 40);
		rc(16'h0002);
		flag(1'b1);
		wr(PTC_OFS_STATUS, 8'h01);
		flag(1'b0);
		wr(PTC_OFS_PERIOD_HIGH, 8'h80);
		wc(16'hfffe);
		win(8'h01, 8);
		rc(16'h0000);
		flag(1'b1);
		wr(PTC_OFS_STATUS, 8'h01);
		wr(PTC_OFS_PERIOD_HIGH, 8'h00);
		wc(16'h0000);
		wr(PTC_OFS_CONTROL, 8'h21);
		repeat (40) @(posedge ref_clk_i);
		chk("run", 16'h0, {15'h0, timer_run_o});
		rc(16'h0000);
		flag(1'b1);
		wr(PTC_OFS_STATUS, 8'h01);
		@(posedge ref_clk_i);
		capture_one_mode_i <= 4'he;
		wr(PTC_OFS_CONTROL, 8'h20);
		prt_u.capture();
		repeat (30) @(posedge ref_clk_i);
		flag(1'b1);
		chk("run", 16'h0, {15'h0, timer_run_o});
		close_out();
	end
endmodule : ptc_timer_tb_top
`default_nettype wire
